// ### hex_ascii.sv
`timescale 1ns/100ps

// ==========================================================
// nibble to lower-case ascii hex digit
module hex_ascii (
	input wire logic [3:0] nibble_i,
	output logic [7:0] char_o
);

	always_comb begin
		if (nibble_i < 4'hA) begin
			char_o = 8'h30 + {4'h0, nibble_i};
		end else begin
			char_o = 8'h57 + {4'h0, nibble_i};
		end
	end

endmodule // hex_ascii

// ### service_request_string_reporter.sv
`timescale 1ns/100ps

module service_request_string_reporter
	import srq_report_pkg::*;
#(
	parameter int unsigned SAVE_CYCLES_P = SAVE_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic cmd_valid_i,
	input wire cmd_t cmd_code_i,
	input wire logic [7:0] cmd_data_i,
	input wire logic cmd_last_i,
	output logic cmd_ready_o,
	output logic resp_valid_o,
	output logic [7:0] resp_data_o,
	output logic resp_last_o,
	input wire logic resp_ready_i,
	input wire logic [7:0] status_byte_i,
	input wire logic [7:0] event_status_i,
	input wire logic [15:0] instrument_change_word_0_i,
	input wire logic [15:0] instrument_change_word_1_i,
	input wire logic terminal_mode_i,
	output logic service_request_o,
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	input wire logic tx_ready_i,
	output logic saving_o
);

	// ==========================================================
	// command, enable register and template storage
	logic [7:0] service_request_enable_q, service_request_enable_d;
	logic [7:0] tpl_q [TEMPLATE_MAX], tpl_d [TEMPLATE_MAX];
	logic [5:0] len_q, len_d;
	logic wr_active_q, wr_active_d;
	logic [31:0] save_cnt_q, save_cnt_d;
	logic ready_q, ready_d;
	logic saving_q, saving_d;
	logic srq_q, srq_d;
	logic take;
	logic [5:0] pos;
	resp_state_t rstate_q, rstate_d;

	assign take = cmd_valid_i && ready_q;

	always_comb begin
		service_request_enable_d = service_request_enable_q;
		tpl_d = tpl_q;
		len_d = len_q;
		wr_active_d = wr_active_q;
		save_cnt_d = save_cnt_q;
		pos = wr_active_q ? len_q : 6'h00;
		if (save_cnt_q != 32'h0) begin
			save_cnt_d = save_cnt_q - 32'h1;
		end
		if (take && cmd_code_i == CMD_ENABLE_SET) begin
			service_request_enable_d = cmd_data_i & ENABLE_WRITABLE;
		end
		if (take && cmd_code_i == CMD_STRING_SET) begin
			if (pos < 6'(TEMPLATE_MAX)) begin
				tpl_d[pos] = cmd_data_i;
				len_d = pos + 6'h01;
			end else begin
				len_d = pos;
			end
			wr_active_d = !cmd_last_i;
			if (cmd_last_i) begin
				save_cnt_d = SAVE_CYCLES_P;
			end
		end
		// bit 6 never gates: it is held zero in the register
		srq_d = |(status_byte_i & service_request_enable_q);
		ready_d = (save_cnt_d == 32'h0) && (rstate_d == R_IDLE);
		saving_d = (save_cnt_d != 32'h0);
		if (take && (cmd_code_i == CMD_ENABLE_QUERY || cmd_code_i == CMD_STRING_QUERY)) begin
			ready_d = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			service_request_enable_q <= ENABLE_RESET;
			for (int i = 0; i < TEMPLATE_MAX; i++) begin
				tpl_q[i] <= (i < DEFAULT_LEN) ? DEFAULT_TEMPLATE[8*(DEFAULT_LEN-1-(i % DEFAULT_LEN)) +: 8] : 8'h00;
			end
			len_q <= 6'(DEFAULT_LEN);
			wr_active_q <= 1'b0;
			save_cnt_q <= 32'h0;
			ready_q <= 1'b0;
			saving_q <= 1'b0;
			srq_q <= 1'b0;
		end else begin
			service_request_enable_q <= service_request_enable_d;
			tpl_q <= tpl_d;
			len_q <= len_d;
			wr_active_q <= wr_active_d;
			save_cnt_q <= save_cnt_d;
			ready_q <= ready_d;
			saving_q <= saving_d;
			srq_q <= srq_d;
		end
	end

	// ==========================================================
	// query answers
	logic [5:0] ridx_q, ridx_d;
	logic [7:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d, rlast_q, rlast_d;
	logic [7:0] dig [3];
	logic [7:0] rem;
	logic [5:0] rend;
	logic rslot;

	always_comb begin
		dig[0] = (service_request_enable_q >= 8'h64) ? 8'h01 : 8'h00;
		rem = service_request_enable_q - ((dig[0] != 8'h00) ? 8'h64 : 8'h00);
		dig[1] = rem / 8'h0A;
		dig[2] = rem % 8'h0A;
		rstate_d = rstate_q;
		ridx_d = ridx_q;
		rdata_d = rdata_q;
		rvalid_d = rvalid_q;
		rlast_d = rlast_q;
		rslot = !rvalid_q || resp_ready_i;
		rend = (rstate_q == R_ENABLE) ? 6'h03 : len_q;
		case (rstate_q)
			R_IDLE: begin
				if (take && cmd_code_i == CMD_ENABLE_QUERY) begin
					rstate_d = R_ENABLE;
					ridx_d = (dig[0] != 8'h00) ? 6'h00 : ((dig[1] != 8'h00) ? 6'h01 : 6'h02);
				end else if (take && cmd_code_i == CMD_STRING_QUERY) begin
					rstate_d = R_TEMPLATE;
					ridx_d = 6'h00;
				end
			end
			R_ENABLE, R_TEMPLATE: begin
				if (rslot) begin
					if (ridx_q < rend) begin
						rvalid_d = 1'b1;
						rlast_d = (ridx_q + 6'h01 == rend);
						if (rstate_q == R_ENABLE) begin
							rdata_d = CHAR_ZERO + dig[ridx_q[1:0]];
						end else begin
							rdata_d = tpl_q[ridx_q];
						end
						ridx_d = ridx_q + 6'h01;
					end else begin
						rvalid_d = 1'b0;
						rlast_d = 1'b0;
						rstate_d = R_IDLE;
					end
				end
			end
			default: begin
				rstate_d = R_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rstate_q <= R_IDLE;
			ridx_q <= 6'h00;
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
			rlast_q <= 1'b0;
		end else begin
			rstate_q <= rstate_d;
			ridx_q <= ridx_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			rlast_q <= rlast_d;
		end
	end

	// ==========================================================
	// filled request string on the serial link
	tx_state_t tstate_q, tstate_d;
	logic [5:0] tidx_q, tidx_d;
	logic [2:0] left_q, left_d;
	logic [2:0] field_q, field_d;
	logic [15:0] snap_q [4], snap_d [4];
	logic [7:0] tdata_q, tdata_d;
	logic tvalid_q, tvalid_d;
	logic [15:0] cur_val;
	logic [3:0] nib;
	logic [7:0] hex_char;
	logic [7:0] c;
	logic tslot;

	hex_ascii u_hex (
		.nibble_i(nib),
		.char_o(hex_char)
	);

	always_comb begin
		tstate_d = tstate_q;
		tidx_d = tidx_q;
		left_d = left_q;
		field_d = field_q;
		snap_d = snap_q;
		tdata_d = tdata_q;
		tvalid_d = tvalid_q;
		tslot = !tvalid_q || tx_ready_i;
		cur_val = field_q[2] ? 16'h0000 : snap_q[field_q[1:0]];
		nib = 4'(cur_val >> {left_q - 3'h1, 2'b00});
		c = tpl_q[tidx_q];
		case (tstate_q)
			T_IDLE: begin
				if (srq_d && !srq_q && terminal_mode_i) begin
					tstate_d = T_RUN;
					tidx_d = 6'h00;
					left_d = 3'h0;
					field_d = 3'h0;
					snap_d[0] = {8'h00, status_byte_i};
					snap_d[1] = {8'h00, event_status_i};
					snap_d[2] = instrument_change_word_0_i;
					snap_d[3] = instrument_change_word_1_i;
				end
			end
			T_RUN: begin
				if (tslot) begin
					tvalid_d = 1'b0;
					if (left_q != 3'h0) begin
						tvalid_d = 1'b1;
						tdata_d = hex_char;
						left_d = left_q - 3'h1;
						if (left_q == 3'h1) begin
							field_d = field_q + 3'h1;
						end
					end else if (tidx_q >= len_q) begin
						tstate_d = T_IDLE;
					end else if (c == CHAR_PERCENT && tidx_q + 6'h03 < len_q && tpl_q[tidx_q + 6'h03] == CHAR_X) begin
						left_d = (tpl_q[tidx_q + 6'h02] == CHAR_FOUR) ? 3'h4 : 3'h2;
						tidx_d = tidx_q + 6'h04;
					end else begin
						tvalid_d = 1'b1;
						tdata_d = c;
						tidx_d = tidx_q + 6'h01;
					end
				end
			end
			default: begin
				tstate_d = T_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tstate_q <= T_IDLE;
			tidx_q <= 6'h00;
			left_q <= 3'h0;
			field_q <= 3'h0;
			for (int i = 0; i < 4; i++) begin
				snap_q[i] <= 16'h0000;
			end
			tdata_q <= 8'h00;
			tvalid_q <= 1'b0;
		end else begin
			tstate_q <= tstate_d;
			tidx_q <= tidx_d;
			left_q <= left_d;
			field_q <= field_d;
			snap_q <= snap_d;
			tdata_q <= tdata_d;
			tvalid_q <= tvalid_d;
		end
	end

	// the request string template is held in tpl_q above; CMD_STRING_SET writes it
	assign cmd_ready_o = ready_q;
	assign resp_valid_o = rvalid_q;
	assign resp_data_o = rdata_q;
	assign resp_last_o = rlast_q;
	assign service_request_o = srq_q;
	assign tx_valid_o = tvalid_q;
	assign tx_data_o = tdata_q;
	assign saving_o = saving_q;

endmodule // service_request_string_reporter

// ### service_request_string_reporter_tb_top.sv
`timescale 1ns/100ps
module service_request_string_reporter_tb_top;
	import srq_report_pkg::*;
	logic sys_clk_i, rst_i, cmd_valid_i, cmd_last_i, cmd_ready_o, resp_valid_o, resp_last_o, resp_ready_i;
	logic terminal_mode_i, service_request_o, tx_valid_o, tx_ready_i, saving_o, stall;
	cmd_t cmd_code_i;
	logic [7:0] cmd_data_i, resp_data_o, status_byte_i, event_status_i, tx_data_o;
	logic [15:0] instrument_change_word_0_i, instrument_change_word_1_i;
	int num_errors, num_checks, seed, en, n, k, i, j;
	int vals[6] = '{191, 255, 0, 64, 0, 56};
	string e;
	service_request_string_reporter #(.SAVE_CYCLES_P(20)) service_request_string_reporter_inst (.sys_clk_i, .rst_i,
		.cmd_valid_i, .cmd_code_i, .cmd_data_i, .cmd_last_i, .cmd_ready_o, .resp_valid_o, .resp_data_o, .resp_last_o,
		.resp_ready_i, .status_byte_i, .event_status_i, .instrument_change_word_0_i, .instrument_change_word_1_i,
		.terminal_mode_i, .service_request_o, .tx_valid_o, .tx_data_o, .tx_ready_i, .saving_o);
	srq_host_model srq_host_model_inst (.sys_clk_i, .stall_i(stall), .resp_valid_i(resp_valid_o),
		.resp_data_i(resp_data_o), .resp_last_i(resp_last_o), .resp_ready_o(resp_ready_i), .tx_valid_i(tx_valid_o),
		.tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task send(input cmd_t c, input logic [7:0] d, input logic l);
		@(posedge sys_clk_i);
		cmd_valid_i <= 1'b1;
		cmd_code_i <= c;
		cmd_data_i <= d;
		cmd_last_i <= l;
		n = 0;
		do begin
			@(negedge sys_clk_i);
			n++;
		end while (cmd_ready_o !== 1'b1 && n < 99);
		chk(16'(cmd_ready_o), 16'h0001);
		@(posedge sys_clk_i);
		cmd_valid_i <= 1'b0;
	endtask
	task cmp(inout logic [7:0] q[$], input string s);
		chk(16'(q.size()), 16'(s.len()));
		for (i = 0; i < s.len(); i++) chk(16'(q[i]), 16'(s[i]));
		q.delete();
	endtask
	task query(input cmd_t c, input string s);
		k = srq_host_model_inst.resp_lasts;
		send(c, 8'h00, 1'b0);
		for (n = 0; n < 300 && srq_host_model_inst.resp_lasts == k; n++) @(negedge sys_clk_i);
		cmp(srq_host_model_inst.resp_q, s);
	endtask
	task serial(input string s);
		for (n = 0; n < 400 && srq_host_model_inst.tx_q.size() < s.len(); n++) @(negedge sys_clk_i);
		repeat (20) @(negedge sys_clk_i);
		cmp(srq_host_model_inst.tx_q, s);
	endtask
	task test_done;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		#300000;
		num_errors++;
		test_done;
	end
	always @(posedge sys_clk_i) stall <= 1'($random(seed));
	initial begin
		seed = 47751;
		{rst_i, cmd_valid_i, cmd_last_i, cmd_data_i, status_byte_i, terminal_mode_i, stall} = 21'h100000;
		{event_status_i, instrument_change_word_0_i, instrument_change_word_1_i} = 40'h0;
		cmd_code_i = CMD_ENABLE_SET;
		repeat (16) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(negedge sys_clk_i);
		chk(16'({saving_o, service_request_o, resp_valid_o, tx_valid_o}), 16'h0000);
		query(CMD_STRING_QUERY, "SRQ: %02x %02x %04x %04x");
		for (j = 0; j < 6; j++) begin
			en = j == 4 ? $random(seed) & 255 : vals[j];
			send(CMD_ENABLE_SET, 8'(en), 1'b0);
			query(CMD_ENABLE_QUERY, $sformatf("%0d", en & 191));
		end
		for (j = 0; j < 9; j++) begin
			@(posedge sys_clk_i);
			status_byte_i <= 8'(1 << j);
			repeat (2) @(negedge sys_clk_i);
			chk(16'(service_request_o), 16'(((1 << j) & 56) != 0));
		end
		@(posedge sys_clk_i);
		terminal_mode_i <= 1'b1;
		event_status_i <= 8'($random(seed));
		instrument_change_word_0_i <= 16'($random(seed));
		instrument_change_word_1_i <= 16'($random(seed));
		@(posedge sys_clk_i);
		status_byte_i <= 8'h2C;
		@(negedge sys_clk_i);
		serial($sformatf("SRQ: %02x %02x %04x %04x", status_byte_i, event_status_i, instrument_change_word_0_i,
			instrument_change_word_1_i));
		@(posedge sys_clk_i);
		status_byte_i <= 8'h00;
		terminal_mode_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		status_byte_i <= 8'h08;
		serial("");
		e = "Z%02x";
		for (j = 0; j < 42; j++) send(CMD_STRING_SET, j < 5 ? e[j] : 8'h6B, j == 41);
		@(negedge sys_clk_i);
		chk(16'({saving_o, cmd_ready_o}), 16'h0002);
		for (j = 0; j < 35; j++) e = {e, "k"};
		query(CMD_STRING_QUERY, e);
		@(posedge sys_clk_i);
		terminal_mode_i <= 1'b1;
		status_byte_i <= 8'h00;
		repeat (4) @(posedge sys_clk_i);
		status_byte_i <= 8'h3A;
		serial({"Z3a", e.substr(5, 39)});
		test_done;
	end
endmodule // service_request_string_reporter_tb_top
bind service_request_string_reporter srq_report_properties #(.SAVE_CYCLES_P(SAVE_CYCLES_P)) props_inst (.sys_clk_i,
	.rst_i, .cmd_valid_i, .cmd_code_i, .cmd_last_i, .cmd_ready_o, .resp_valid_o, .resp_data_o, .resp_last_o,
	.resp_ready_i, .status_byte_i, .terminal_mode_i, .service_request_o, .tx_valid_o, .tx_data_o, .tx_ready_i, .saving_o);

// ### srq_host_model.sv
`timescale 1ns/100ps
module srq_host_model (
	input wire logic sys_clk_i,
	input wire logic stall_i,
	input wire logic resp_valid_i,
	input wire logic [7:0] resp_data_i,
	input wire logic resp_last_i,
	output logic resp_ready_o,
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	output logic tx_ready_o
);
	logic [7:0] resp_q[$];
	logic [7:0] tx_q[$];
	int resp_lasts = 0;
	initial begin
		resp_ready_o = 1'b0;
		tx_ready_o = 1'b0;
	end
	// ==========================================================
	// host sink, stalls on request of the bench
	always @(posedge sys_clk_i) begin
		resp_ready_o <= !stall_i;
		tx_ready_o <= !stall_i;
		if (resp_valid_i && resp_ready_o) begin
			resp_q.push_back(resp_data_i);
			resp_lasts <= resp_lasts + resp_last_i;
		end
		if (tx_valid_i && tx_ready_o) tx_q.push_back(tx_data_i);
	end
endmodule // srq_host_model

// ### srq_report_pkg.sv
package srq_report_pkg;

	// ==========================================================
	// command codes from the upstream parser
	typedef enum logic [1:0] {
		CMD_ENABLE_SET = 2'h0,
		CMD_ENABLE_QUERY = 2'h1,
		CMD_STRING_SET = 2'h2,
		CMD_STRING_QUERY = 2'h3
	} cmd_t;

	// ==========================================================
	// state machines
	typedef enum logic [1:0] {
		R_IDLE = 2'h0,
		R_ENABLE = 2'h1,
		R_TEMPLATE = 2'h2
	} resp_state_t;

	typedef enum logic [0:0] {
		T_IDLE = 1'h0,
		T_RUN = 1'h1
	} tx_state_t;

	// ==========================================================
	// register layout
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] ENABLE_WRITABLE = 8'hBF;
	localparam int ENABLE_ERR_BIT = 3;
	localparam int ENABLE_MSG_BIT = 4;
	localparam int ENABLE_EVT_BIT = 5;
	localparam int ENABLE_UNUSED_BIT = 6;

	// ==========================================================
	// template storage
	localparam int TEMPLATE_MAX = 40;
	localparam int DEFAULT_LEN = 24;
	localparam logic [8*DEFAULT_LEN-1:0] DEFAULT_TEMPLATE = "SRQ: %02x %02x %04x %04x";
	localparam logic [7:0] CHAR_PERCENT = 8'h25;
	localparam logic [7:0] CHAR_X = 8'h78;
	localparam logic [7:0] CHAR_ZERO = 8'h30;
	localparam logic [7:0] CHAR_FOUR = 8'h34;

	// ==========================================================
	// timing
	localparam longint CLOCK_HZ = 100000000;
	localparam longint SAVE_TIME_MS = 2000;
	localparam int SAVE_CYCLES = int'(SAVE_TIME_MS * CLOCK_HZ / 1000);

endpackage

// ### srq_report_properties.sv
`timescale 1ns/100ps
module srq_report_properties
	import srq_report_pkg::*;
#(
	parameter int unsigned SAVE_CYCLES_P = 20
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic cmd_valid_i,
	input wire cmd_t cmd_code_i,
	input wire logic cmd_last_i,
	input wire logic cmd_ready_o,
	input wire logic resp_valid_o,
	input wire logic [7:0] resp_data_o,
	input wire logic resp_last_o,
	input wire logic resp_ready_i,
	input wire logic [7:0] status_byte_i,
	input wire logic terminal_mode_i,
	input wire logic service_request_o,
	input wire logic tx_valid_o,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_ready_i,
	input wire logic saving_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	int unsigned save_cnt_q;
	int unsigned save_cnt_d;
	always_comb save_cnt_d = saving_o ? save_cnt_q + 1 : 0;
	always_ff @(posedge sys_clk_i) save_cnt_q <= rst_i ? 0 : save_cnt_d;
	sequence take_s(cmd_t c);
		cmd_valid_i && cmd_ready_o && cmd_code_i == c;
	endsequence
	sequence tx_trigger_s;
		$rose(service_request_o) && $past(terminal_mode_i) == 1'b1 && $past(tx_valid_o) == 1'b0 && !tx_valid_o;
	endsequence
	AST_SAVE_REFUSE: assert property (saving_o |-> !cmd_ready_o)
		else $error("command accepted while saving");
	AST_SAVE_START: assert property (take_s(CMD_STRING_SET) ##0 cmd_last_i |-> ##[1:2] saving_o)
		else $error("no save after last template char");
	AST_SAVE_LEN: assert property (save_cnt_q <= SAVE_CYCLES_P)
		else $error("save period too long");
	AST_ENABLE_ANSWER: assert property (take_s(CMD_ENABLE_QUERY) |-> ##2 resp_valid_o && resp_data_o inside {[8'h30:8'h39]})
		else $error("enable answer not a digit in time");
	AST_TEMPLATE_ANSWER: assert property (take_s(CMD_STRING_QUERY) |=> !cmd_ready_o ##1 resp_valid_o)
		else $error("template answer late");
	AST_RESP_HOLD: assert property (resp_valid_o && !resp_ready_i |=> resp_valid_o && $stable(resp_data_o) && $stable(resp_last_o))
		else $error("answer byte dropped");
	AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
		else $error("serial byte dropped");
	AST_SRQ_GATE: assert property (status_byte_i == 8'h00 |=> !service_request_o)
		else $error("request without status");
	AST_TX_MODE: assert property (!tx_valid_o && !terminal_mode_i && $past(terminal_mode_i, 3) == 1'b0 |=> !tx_valid_o)
		else $error("string sent outside terminal mode");
	AST_TX_START: assert property (tx_trigger_s |-> ##[1:3] tx_valid_o)
		else $error("request string not started");
endmodule // srq_report_properties
